// ---- hdl/eiwp_fifo.sv ----
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module eiwp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
)
(
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             wrValid,
   output logic                  wrReady,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  rdValid,
   input  wire logic             rdReady,
   output logic      [WIDTH-1:0] rdData
);
   import eiwp_pkg::*;

   localparam int PW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [PW:0] wp;
      logic [PW:0] rp;
   } eiwp_fifo_s;

   eiwp_fifo_s       r_reg;
   eiwp_fifo_s       r_next;
   logic [WIDTH-1:0] store [DEPTH];
   logic             full;
   logic             empty;

   ////////////////////////////////////////////////////////////////////////
   // Extra pointer bit tells full from empty
   assign full    = (r_reg.wp[PW] != r_reg.rp[PW]) &&
                    (r_reg.wp[PW-1:0] == r_reg.rp[PW-1:0]);
   assign empty   = (r_reg.wp == r_reg.rp);
   assign wrReady = !full;
   assign rdValid = !empty;
   assign rdData  = store[r_reg.rp[PW-1:0]];

   // Pointer update
   always_comb
   begin
      r_next = r_reg;
      if (wrValid && !full)
         r_next.wp = r_reg.wp + 1'b1;
      if (rdReady && !empty)
         r_next.rp = r_reg.rp + 1'b1;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   // Data storage needs no reset
   always_ff @(posedge ref_clk)
   begin
      if (wrValid && !full)
         store[r_reg.wp[PW-1:0]] <= wrData;
   end

endmodule
`default_nettype wire

// ---- hdl/eiwp_nv_store.sv ----
// Non-volatile array, page latch, protection flags and write-cycle timer
`timescale 1ns/1ps
`default_nettype none
module eiwp_nv_store #(
   parameter int WRITE_CYC = eiwp_pkg::WRITE_CYCLES
)
(
   input  wire logic                ref_clk,
   input  wire logic                reset,
   input  wire logic                cmdValid,
   output logic                     cmdReady,
   input  wire eiwp_pkg::eiwp_cmd_s cmd,
   input  wire logic [7:0]          rdAddr,
   output logic      [7:0]          rdData,
   output logic                     wrBusy,
   output logic                     tempProt,
   output logic                     permProt
);
   import eiwp_pkg::*;

   typedef struct packed
   {
      logic             busy;
      logic [CNT_W-1:0] count;
      eiwp_op_e         op;
   } eiwp_timer_s;

   eiwp_timer_s     r_reg;
   eiwp_timer_s     r_next;
   logic            commitNow;
   logic            take;
   // Cells below survive reset, standing in for power cycles
   logic [7:0]      mem [MEM_WORDS];
   logic [7:0]      page [PAGE_BYTES];
   logic [15:0]     mask;
   logic [3:0]      pageHi;
   logic            tempProt_reg = 1'b0;
   logic            permProt_reg = 1'b0;

   initial
   begin
      for (int i = 0; i < MEM_WORDS; i++)
         mem[i] = ERASED_BYTE;
   end

   ////////////////////////////////////////////////////////////////////////
   // Commands are refused while the write cycle runs
   assign cmdReady = !r_reg.busy;
   assign take     = cmdValid && !r_reg.busy;
   assign wrBusy   = r_reg.busy;
   assign tempProt = tempProt_reg;
   assign permProt = permProt_reg;
   assign rdData   = mem[rdAddr];

   // Busy from any command other than a latch until the count runs out
   always_comb
   begin
      r_next    = r_reg;
      commitNow = 1'b0;
      if (r_reg.busy)
      begin
         r_next.count = r_reg.count - 1'b1;
         if (r_reg.count == '0)
         begin
            r_next.busy = 1'b0;
            commitNow   = 1'b1;
         end
      end
      else if (take && cmd.op != OP_LATCH)
      begin
         r_next.busy  = 1'b1;
         r_next.count = CNT_W'(WRITE_CYC - 1);
         r_next.op    = cmd.op;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         r_reg <= '{busy: 1'b0, count: '0, op: OP_LATCH};
      else
         r_reg <= r_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // Page latch fills during the transfer, array updated at cycle end;
   // plain always since the power-up image is also written at time zero
   always @(posedge ref_clk)
   begin
      if (take && cmd.op == OP_LATCH)
      begin
         if (cmd.keep)
            page[cmd.addr[3:0]] <= cmd.data;
         if (cmd.first)
            mask <= 16'h0000;
         mask[cmd.addr[3:0]] <= cmd.keep;
         pageHi <= cmd.addr[7:4];
      end
      if (commitNow && r_reg.op == OP_COMMIT)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
            if (mask[i])
               mem[{pageHi, 4'(i)}] <= page[i];
      end
   end

   // Protection levels kept across power cycles; lock never clears
   always @(posedge ref_clk)
   begin
      if (commitNow && r_reg.op == OP_SET)
         tempProt_reg <= 1'b1;
      if (commitNow && r_reg.op == OP_CLEAR)
         tempProt_reg <= 1'b0;
      if (commitNow && r_reg.op == OP_LOCK)
         permProt_reg <= 1'b1;
   end

endmodule
`default_nettype wire

// ---- hdl/eiwp_pkg.sv ----
// Shared constants and types of the two-wire EEPROM slave with write protect
package eiwp_pkg;

   // Device type codes of the select byte
   localparam logic [3:0] MEM_TYPE     = 4'ha;
   localparam logic [3:0] PROT_TYPE    = 4'h6;
   // Select byte field positions
   localparam int         TYPE_MSB     = 7;
   localparam int         TYPE_LSB     = 4;
   localparam int         RW_BIT       = 0;
   // Lower half of the array is the protectable area
   localparam int         PROT_ADDR_BIT = 7;
   localparam logic [3:0] BYTE_DONE    = 4'h8;
   localparam logic [7:0] ADDR_RESET   = 8'h00;
   localparam logic [7:0] ERASED_BYTE  = 8'hff;
   localparam int         MEM_WORDS    = 256;
   localparam int         PAGE_BYTES   = 16;

   // Write cycle timing; the cycle is a least time, so it rounds up
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         WRITE_TIME_NS = 5000000;
   localparam int         WRITE_CYCLES  =
      (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         CNT_W        = 24;

   // Command queue depth
   localparam int         FIFO_DEPTH   = 4;

   typedef enum logic [2:0]
   {
      OP_LATCH,
      OP_COMMIT,
      OP_SET,
      OP_CLEAR,
      OP_LOCK
   } eiwp_op_e;

   // One command from the bus engine to the non-volatile store
   typedef struct packed
   {
      eiwp_op_e   op;
      logic       first;
      logic       keep;
      logic [7:0] addr;
      logic [7:0] data;
   } eiwp_cmd_s;

   localparam int         CMD_W = $bits(eiwp_cmd_s);

endpackage

// ---- hdl/eiwp_slave.sv ----
// Two-wire serial slave for a 256-byte EEPROM with lower-half protection
`timescale 1ns/1ps
`default_nettype none
module eiwp_slave #(
   parameter int WRITE_CYC = eiwp_pkg::WRITE_CYCLES
)
(
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   output logic      sdaOut,
   output logic      sdaOe,
   input  wire logic selectAddrPinLow,
   input  wire logic selectAddrPinMid,
   input  wire logic selectAddrPinHigh,
   input  wire logic highVoltageLevel
);
   import eiwp_pkg::*;

   typedef enum logic [3:0]
   {
      ST_IDLE, ST_SELECT, ST_ACK_SEL, ST_ADDR, ST_ACK_ADDR, ST_WDATA,
      ST_ACK_WDATA, ST_RLOAD, ST_RDATA, ST_RACK, ST_QDATA, ST_QACK,
      ST_IGNORE
   } eiwp_state_e;

   typedef enum logic [2:0]
   {
      K_MEM_W, K_MEM_R, K_QTEMP, K_QLOCK, K_SET, K_CLEAR, K_LOCK
   } eiwp_kind_e;

   typedef struct packed
   {
      eiwp_state_e state;
      eiwp_kind_e  kind;
      logic [3:0]  bitCnt;
      logic [7:0]  shift;
      logic [7:0]  addr;
      logic        tenth;
      logic        wrote;
      logic        sclPrev;
      logic        sdaPrev;
      logic        sdaOut;
      logic        sdaOe;
      logic        pushValid;
      eiwp_cmd_s   pushCmd;
   } eiwp_slave_s;

   eiwp_slave_s r_reg;
   eiwp_slave_s r_next;
   logic        rise;
   logic        fall;
   logic        startSeen;
   logic        stopSeen;
   logic        cmdReady;
   logic        qValid;
   logic        qReady;
   eiwp_cmd_s   qCmd;
   logic [7:0]  rdData;
   logic        wrBusy;
   logic        tempProt;
   logic        permProt;

   ////////////////////////////////////////////////////////////////////////
   // Lower half is protected while either flag is set
   function automatic logic isProtected(input logic [7:0] a,
                                        input logic       t,
                                        input logic       p);
      isProtected = (t || p) && !a[PROT_ADDR_BIT];
   endfunction

   // Bus conditions from the previous sample; inputs are synchronous
   assign rise      = sclIn && !r_reg.sclPrev;
   assign fall      = !sclIn && r_reg.sclPrev;
   assign startSeen = sclIn && r_reg.sclPrev && r_reg.sdaPrev && !sdaIn;
   assign stopSeen  = sclIn && r_reg.sclPrev && !r_reg.sdaPrev && sdaIn;

   ////////////////////////////////////////////////////////////////////////
   // Bus engine
   always_comb
   begin
      logic       ackIt;
      logic       selMatch;
      logic       prot;
      eiwp_kind_e kind;
      ackIt    = 1'b0;
      prot     = 1'b0;
      kind     = r_reg.kind;
      // Address bits compare against pins; high voltage reads as one
      selMatch = r_reg.shift[3:1] ==
                 {selectAddrPinHigh, selectAddrPinMid,
                  selectAddrPinLow | highVoltageLevel};
      r_next         = r_reg;
      r_next.sclPrev = sclIn;
      r_next.sdaPrev = sdaIn;
      // A held push waits for queue space rather than being lost
      if (r_reg.pushValid && cmdReady)
         r_next.pushValid = 1'b0;

      if (wrBusy)
      begin
         // No answer at all while the array is being written
         r_next.state = ST_IDLE;
         r_next.sdaOe = 1'b0;
         r_next.tenth = 1'b0;
         r_next.wrote = 1'b0;
      end
      else if (startSeen)
      begin
         // Restart keeps the address, so a dummy write sets it
         r_next.state  = ST_SELECT;
         r_next.bitCnt = 4'h0;
         r_next.sdaOe  = 1'b0;
         r_next.tenth  = 1'b0;
         r_next.wrote  = 1'b0;
      end
      else if (stopSeen)
      begin
         if (r_reg.tenth && r_reg.wrote)
         begin
            r_next.pushValid    = 1'b1;
            r_next.pushCmd      = '0;
            r_next.pushCmd.addr = r_reg.addr;
            case (r_reg.kind)
               K_SET:   r_next.pushCmd.op = OP_SET;
               K_CLEAR: r_next.pushCmd.op = OP_CLEAR;
               K_LOCK:  r_next.pushCmd.op = OP_LOCK;
               default: r_next.pushCmd.op = OP_COMMIT;
            endcase
         end
         r_next.state = ST_IDLE;
         r_next.sdaOe = 1'b0;
         r_next.tenth = 1'b0;
      end
      else if (rise)
      begin
         case (r_reg.state)
            ST_SELECT, ST_ADDR, ST_WDATA:
            begin
               r_next.shift  = {r_reg.shift[6:0], sdaIn};
               r_next.bitCnt = r_reg.bitCnt + 1'b1;
            end
            ST_RDATA, ST_QDATA:
               r_next.bitCnt = r_reg.bitCnt + 1'b1;
            ST_RACK:
               // Released line in the ninth slot ends the read
               r_next.state = sdaIn ? ST_IDLE : ST_RLOAD;
            default:
               r_next.state = r_reg.state;
         endcase
      end
      else if (fall)
      begin
         // Slot ten spans the clock high of a stop, so it ends on a fall
         r_next.tenth = 1'b0;
         case (r_reg.state)
            ST_SELECT:
               if (r_reg.bitCnt == BYTE_DONE)
               begin
                  if (selMatch &&
                      r_reg.shift[TYPE_MSB:TYPE_LSB] == MEM_TYPE)
                  begin
                     ackIt = 1'b1;
                     kind  = r_reg.shift[RW_BIT] ? K_MEM_R : K_MEM_W;
                  end
                  else if (selMatch && !permProt &&
                           r_reg.shift[TYPE_MSB:TYPE_LSB] == PROT_TYPE)
                  begin
                     if (r_reg.shift[RW_BIT])
                     begin
                        if (highVoltageLevel && !selectAddrPinHigh &&
                            !selectAddrPinMid)
                        begin
                           ackIt = 1'b1;
                           kind  = K_QTEMP;
                        end
                        else if (!highVoltageLevel)
                        begin
                           ackIt = 1'b1;
                           kind  = K_QLOCK;
                        end
                     end
                     else if (highVoltageLevel)
                     begin
                        // Both need the high pin low; set refused when already set, clear taken whatever the flag
                        ackIt = !selectAddrPinHigh &&
                                (selectAddrPinMid || !tempProt);
                        kind  = selectAddrPinMid ? K_CLEAR : K_SET;
                     end
                     else
                     begin
                        ackIt = 1'b1;
                        kind  = K_LOCK;
                     end
                  end
                  r_next.kind  = kind;
                  r_next.sdaOe = ackIt;
                  r_next.state = ackIt ? ST_ACK_SEL : ST_IGNORE;
               end
            ST_ACK_SEL, ST_RLOAD:
            begin
               // First read bit goes out on the fall that ends the ack
               r_next.sdaOe  = 1'b0;
               r_next.bitCnt = 4'h0;
               case (r_reg.kind)
                  K_MEM_R:
                  begin
                     // Array read needs no protection check
                     r_next.shift = rdData;
                     r_next.sdaOe = !rdData[7];
                     r_next.addr  = r_reg.addr + 8'h01;
                     r_next.state = ST_RDATA;
                  end
                  K_QTEMP, K_QLOCK: r_next.state = ST_QDATA;
                  default: r_next.state = ST_ADDR;
               endcase
            end
            ST_ADDR:
               if (r_reg.bitCnt == BYTE_DONE)
               begin
                  // Protect commands take the byte but ignore it
                  if (r_reg.kind == K_MEM_W)
                     r_next.addr = r_reg.shift;
                  r_next.sdaOe = 1'b1;
                  r_next.state = ST_ACK_ADDR;
               end
            ST_ACK_ADDR, ST_ACK_WDATA:
            begin
               r_next.sdaOe  = 1'b0;
               r_next.bitCnt = 4'h0;
               r_next.tenth  = (r_reg.state == ST_ACK_WDATA);
               r_next.state  = ST_WDATA;
            end
            ST_WDATA:
               if (r_reg.bitCnt == BYTE_DONE)
               begin
                  if (r_reg.kind == K_MEM_W)
                  begin
                     // Locked area answers no-ack and keeps its data
                     prot = isProtected(r_reg.addr, tempProt,
                                        permProt);
                     r_next.pushValid     = 1'b1;
                     r_next.pushCmd.op    = OP_LATCH;
                     r_next.pushCmd.first = !r_reg.wrote;
                     r_next.pushCmd.keep  = !prot;
                     r_next.pushCmd.addr  = r_reg.addr;
                     r_next.pushCmd.data  = r_reg.shift;
                     // Address rolls within the page only
                     r_next.addr = {r_reg.addr[7:4],
                                    r_reg.addr[3:0] + 4'h1};
                  end
                  r_next.sdaOe = !prot;
                  r_next.wrote = 1'b1;
                  r_next.state = ST_ACK_WDATA;
               end
            ST_RDATA:
               if (r_reg.bitCnt == BYTE_DONE)
               begin
                  r_next.sdaOe = 1'b0;
                  r_next.state = ST_RACK;
               end
               else
               begin
                  r_next.shift = {r_reg.shift[6:0], 1'b0};
                  r_next.sdaOe = !r_reg.shift[6];
               end
            ST_QDATA:
               if (r_reg.bitCnt == BYTE_DONE)
               begin
                  r_next.sdaOe = (r_reg.kind == K_QTEMP) ?
                                 !tempProt :
                                 !permProt;
                  r_next.state = ST_QACK;
               end
            ST_QACK:
            begin
               r_next.sdaOe = 1'b0;
               r_next.state = ST_IGNORE;
            end
            default:
               r_next.sdaOe = 1'b0;
         endcase
      end
   end

   // State register; line driven only low, so the data level stays 0
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         r_reg         <= '0;
         r_reg.state   <= ST_IDLE;
         r_reg.kind    <= K_MEM_W;
         r_reg.addr    <= ADDR_RESET;
         r_reg.sclPrev <= 1'b1;
         r_reg.sdaPrev <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   assign sdaOut = r_reg.sdaOut;
   assign sdaOe  = r_reg.sdaOe;

   ////////////////////////////////////////////////////////////////////////
   // Command queue decouples the bus engine from the store
   eiwp_fifo #(
      .WIDTH (CMD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .reset   (reset),
      .wrValid (r_reg.pushValid),
      .wrReady (cmdReady),
      .wrData  (r_reg.pushCmd),
      .rdValid (qValid),
      .rdReady (qReady),
      .rdData  (qCmd)
   );

   eiwp_nv_store #(
      .WRITE_CYC (WRITE_CYC)
   ) u_store (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .cmdValid (qValid),
      .cmdReady (qReady),
      .cmd      (qCmd),
      .rdAddr   (r_reg.addr),
      .rdData   (rdData),
      .wrBusy   (wrBusy),
      .tempProt (tempProt),
      .permProt (permProt)
   );

endmodule
`default_nettype wire

// ---- tb/eiwp_bus_master.sv ----
// Behavioural two-wire bus master driving the EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module eiwp_bus_master
(
   input  wire logic       ref_clk,
   input  wire logic       sdaLine,
   output logic            sclOut,
   output logic            sdaDrv,
   output logic            resStb,
   output logic [8:0]      resVal
);
   // Lines idle high, as with the bus pull-ups
   initial
   begin
      sclOut = 1'b1;
      sdaDrv = 1'b1;
      resStb = 1'b0;
      resVal = 9'h000;
   end
   ////////////////////////////////////////
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Data moves only while the clock is low; read while clock high
   task automatic bitIo(input logic b, output logic r);
      sdaDrv <= b;
      w(4);
      sclOut <= 1'b1;
      w(4);
      r = sdaLine;
      sclOut <= 1'b0;
      w(2);
   endtask
   // Byte MSB first, then slot 9; result is {byte, slot 9 level}
   task automatic xfer(input logic [7:0] d, input logic a);
      logic [8:0] q;
      for (int i = 7; i >= 0; i--)
         bitIo(d[i], q[i+1]);
      bitIo(a, q[0]);
      resVal <= q;
      resStb <= 1'b1;
      w(1);
      resStb <= 1'b0;
   endtask
   // Start or repeated start, also used to poll a busy device
   task automatic start();
      sdaDrv <= 1'b1;
      w(2);
      sclOut <= 1'b1;
      w(4);
      sdaDrv <= 1'b0;
      w(4);
      sclOut <= 1'b0;
      w(2);
   endtask
   // Stop; only issued at byte boundaries
   task automatic stop();
      sdaDrv <= 1'b0;
      w(2);
      sclOut <= 1'b1;
      w(4);
      sdaDrv <= 1'b1;
      w(4);
   endtask
endmodule
`default_nettype wire

// ---- tb/eiwp_slave_chk.sv ----
// Pin-level assertions for the two-wire EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module eiwp_slave_chk #(
   parameter int WRITE_CYC = 20
)
(
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic sclIn,
   input  wire logic sdaIn,
   input  wire logic sdaOut,
   input  wire logic sdaOe,
   input  wire logic selectAddrPinLow,
   input  wire logic selectAddrPinMid,
   input  wire logic selectAddrPinHigh,
   input  wire logic highVoltageLevel
);
   // Longest pull: ack plus eight zero bits at the bench bit time
   localparam int MAX_RUN = 120;
   logic [7:0] oeRun_reg;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Length of the present pull-low run
   always_ff @(posedge ref_clk or posedge reset)
      if (reset)
         oeRun_reg <= 8'h00;
      else
         oeRun_reg <= sdaOe ? oeRun_reg + 8'h01 : 8'h00;
   sequence stopSeq;
      sclIn && $past(sclIn) && $rose(sdaIn);
   endsequence
   ////////////////////////////////////////
   chk_drive_low: assert property (sdaOut == 1'b0)
      else $error("data output value not low");
   chk_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
      else $error("data pull changed while clock high");
   chk_oe_after_fall: assert property (
      $rose(sdaOe) |-> $past(sclIn, 2) || $past(sclIn, 3) || $past(sclIn, 4))
      else $error("data pull began without a clock fall");
   chk_oe_stands: assert property ($rose(sdaOe) |=> sdaOe [*6])
      else $error("data pull dropped early");
   chk_release_run: assert property (oeRun_reg < MAX_RUN)
      else $error("data line held low too long");
   chk_idle_stop: assert property (stopSeq |=> !sdaOe [*8])
      else $error("device drove after a stop");
   chk_reset_quiet: assert property ($fell(reset) |-> !sdaOe)
      else $error("device drove right after reset");
   chk_start_clean: assert property (
      sclIn && $past(sclIn) && $fell(sdaIn) |-> !sdaOe)
      else $error("device pulled data at a start");
   cov_ack: cover property ($rose(sdaOe));
   cov_stop: cover property (stopSeq);
   cov_hv_ack: cover property (highVoltageLevel && $rose(sdaOe));
endmodule
bind eiwp_slave eiwp_slave_chk #(.WRITE_CYC(WRITE_CYC)) u_chk
(
   .ref_clk           (ref_clk),
   .reset             (reset),
   .sclIn             (sclIn),
   .sdaIn             (sdaIn),
   .sdaOut            (sdaOut),
   .sdaOe             (sdaOe),
   .selectAddrPinLow  (selectAddrPinLow),
   .selectAddrPinMid  (selectAddrPinMid),
   .selectAddrPinHigh (selectAddrPinHigh),
   .highVoltageLevel  (highVoltageLevel)
);
`default_nettype wire

// ---- tb/eiwp_slave_tb.sv ----
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module eiwp_slave_tb;
   import eiwp_pkg::*;
   localparam int WC = 20;
   logic        ref_clk;
   logic        reset;
   logic        sclM;
   logic        sdaM;
   logic        sdaOut;
   logic        sdaOe;
   logic [2:0]  pins;
   logic        hv;
   logic        resStb;
   logic [8:0]  resVal;
   logic [7:0]  mem [256];
   logic [17:0] expQ [$];
   int          fails;
   int          cmp_count;
   int          cyc;
   // Open-drain data line with pull-up
   wire         sdaLine = sdaM & (sdaOe ? sdaOut : 1'b1);
   eiwp_slave #(.WRITE_CYC(WC)) u_dut
   (
      .ref_clk           (ref_clk),
      .reset             (reset),
      .sclIn             (sclM),
      .sdaIn             (sdaLine),
      .sdaOut            (sdaOut),
      .sdaOe             (sdaOe),
      .selectAddrPinLow  (pins[0]),
      .selectAddrPinMid  (pins[1]),
      .selectAddrPinHigh (pins[2]),
      .highVoltageLevel  (hv)
   );
   eiwp_bus_master u_m
   (
      .ref_clk (ref_clk),
      .sdaLine (sdaLine),
      .sclOut  (sclM),
      .sdaDrv  (sdaM),
      .resStb  (resStb),
      .resVal  (resVal)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Expectation is {value, mask}; value already masked
   task automatic check(input logic [8:0] got, input logic [17:0] e);
      cmp_count++;
      if ((got & e[8:0]) !== e[17:9])
      begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, e[17:9]);
      end
   endtask
   always @(posedge ref_clk)
      if (resStb === 1'b1)
         check(resVal, expQ.pop_front());
   // Hang guard, well above the expected run length
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fails++;
         summarize();
      end
   end
   ////////////////////////////////////////
   function automatic logic [7:0] sel(input logic [3:0] t, input logic rw);
      return {t, pins[2:1], pins[0] | hv, rw};
   endfunction
   task automatic tx(input logic [7:0] d, input logic nak);
      expQ.push_back({8'h00, nak, 9'h001});
      u_m.xfer(d, 1'b1);
   endtask
   task automatic rx(input logic [7:0] d, input logic mNak);
      expQ.push_back({d, 1'b0, 9'h1fe});
      u_m.xfer(8'hff, mNak);
   endtask
   // Poll at once (busy, refused), then again once the cycle is over
   task automatic wcyc();
      u_m.start();
      tx(sel(MEM_TYPE, 1'b0), 1'b1);
      u_m.stop();
      u_m.w(WC);
      u_m.start();
      tx(sel(MEM_TYPE, 1'b0), 1'b0);
      u_m.stop();
   endtask
   task automatic wrAt(input logic [7:0] a, input int n, input logic nak);
      logic [7:0] d;
      u_m.start();
      tx(sel(MEM_TYPE, 1'b0), 1'b0);
      tx(a, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         tx(d, nak);
         if (!nak)
            mem[{a[7:4], 4'(a[3:0] + i)}] = d;
      end
      u_m.stop();
      wcyc();
   endtask
   // Dummy write, restart, read n bytes, end with no-ack and stop
   task automatic rdAt(input logic [7:0] a, input int n);
      u_m.start();
      tx(sel(MEM_TYPE, 1'b0), 1'b0);
      tx(a, 1'b0);
      u_m.start();
      tx(sel(MEM_TYPE, 1'b1), 1'b0);
      for (int i = 0; i < n; i++)
         rx(mem[8'(a + i)], i == n - 1);
      u_m.stop();
   endtask
   // Protection command or status query; st is the slot-9 answer
   task automatic pcmd(input logic rw, input logic nak, input logic st);
      u_m.start();
      tx(sel(PROT_TYPE, rw), nak);
      if (!nak)
      begin
         tx(rw ? 8'hff : 8'($urandom), st);
         if (!rw)
            tx(8'($urandom), 1'b0);
      end
      u_m.stop();
      if (!nak && !rw)
         wcyc();
   endtask
   ////////////////////////////////////////
   initial
   begin
      reset = 1'b1;
      hv = 1'b0;
      fails = 0;
      cmp_count = 0;
      cyc = 0;
      for (int i = 0; i < 256; i++)
         mem[i] = ERASED_BYTE;
      void'($urandom(13));
      pins = 3'($urandom);
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      // Memory: byte, current read and abandon, page, wrap, stray stop
      wrAt(8'h90, 1, 1'b0);
      rdAt(8'h90, 1);
      u_m.start();
      tx(sel(MEM_TYPE, 1'b1), 1'b0);
      rx(mem[8'h91], 1'b1);
      expQ.push_back({8'hff, 1'b1, 9'h1ff});
      u_m.xfer(8'hff, 1'b1);
      u_m.stop();
      wrAt(8'hf4, 16, 1'b0);
      rdAt(8'hfe, 3);
      u_m.start();
      tx(sel(4'h3, 1'b0), 1'b1);
      tx(sel(MEM_TYPE, 1'b0), 1'b1);
      u_m.start();
      tx(sel(MEM_TYPE, 1'b0), 1'b0);
      tx(8'h10, 1'b0);
      u_m.stop();
      u_m.start();
      tx(sel(MEM_TYPE, 1'b0), 1'b0);
      u_m.stop();
      // Temporary protection
      hv <= 1'b1;
      pins <= 3'h0;
      pcmd(1'b1, 1'b0, 1'b0);
      pcmd(1'b0, 1'b0, 1'b0);
      pcmd(1'b0, 1'b1, 1'b0);
      pcmd(1'b1, 1'b0, 1'b1);
      wrAt(8'h05, 1, 1'b1);
      wrAt(8'h85, 2, 1'b0);
      rdAt(8'h05, 1);
      pins <= 3'h4;
      pcmd(1'b0, 1'b1, 1'b0);
      pins <= 3'h2;
      pcmd(1'b0, 1'b0, 1'b0);
      pins <= 3'h0;
      pcmd(1'b1, 1'b0, 1'b0);
      wrAt(8'h05, 1, 1'b0);
      // Permanent lock, then a reset in mid-run
      hv <= 1'b0;
      pcmd(1'b1, 1'b0, 1'b0);
      pcmd(1'b0, 1'b0, 1'b0);
      pcmd(1'b1, 1'b1, 1'b0);
      wrAt(8'h20, 2, 1'b1);
      rdAt(8'h20, 2);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      pcmd(1'b0, 1'b1, 1'b0);
      wrAt(8'h7f, 1, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
